/* common/fps_pkg.sv */
// Package for the flash protection and security block: map, fields, resets and carriers.
package fps_pkg;

    // Register byte offsets on the Wishbone slave.
    localparam logic [3:0] ADR_PROT = 4'h0;
    localparam logic [3:0] ADR_OPT  = 4'h4;
    localparam logic [3:0] ADR_CFG  = 4'h8;
    localparam logic [3:0] ADR_STAT = 4'hc;

    // Nonvolatile byte locations inside the flash array.
    localparam logic [15:0] NV_PROT_ADDR = 16'hffbd;
    localparam logic [15:0] NV_OPT_ADDR  = 16'hffbf;
    localparam logic [15:0] KEY_BASE     = 16'hffb0;

    // Memory map.
    localparam logic [15:0] FLASH_BASE = 16'he000;
    localparam logic [15:0] FLASH_TOP  = 16'hffff;
    localparam logic [15:0] RAM_BASE   = 16'h0080;
    localparam logic [15:0] RAM_TOP    = 16'h027f;
    localparam logic [15:0] VEC_LO     = 16'hffc0;
    localparam logic [15:0] VEC_HI     = 16'hfffd;

    // Field positions.
    localparam int PROT_DIS_BIT   = 0;
    localparam int OPT_BACKDOOR_KEY_ENABLE_BIT  = 7;
    localparam int OPT_NORED_BIT  = 6;
    localparam int CFG_KEY_ACCESS_BIT_BIT = 5;
    localparam int BLOCK_BITS     = 9;
    localparam int VEC_AREA_BITS  = 6;
    localparam int KEY_LEN        = 8;

    // Field values and reset values.
    localparam logic [1:0] SEC_OPEN  = 2'h2;
    localparam logic [7:0] PROT_RST  = 8'hff;
    localparam logic [7:0] OPT_RST   = 8'hff;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] OPT_MASK  = 8'hc3;

    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_ENTRY = 3'b010,
        KEY_FULL  = 3'b100
    } fps_key_e;

    // Memory request from the core or the debug controller.
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic        we;
        logic [7:0]  wdata;
        logic        src_secure;
        logic        src_bdc;
    } fps_mreq_s;

    // Request passed on to the flash and RAM arrays.
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic        we;
        logic [7:0]  wdata;
    } fps_areq_s;

endpackage

/* design/fps_protect.sv */
// Flash block protection, vector redirection and security gating.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Function
// RQ1 - Block program and erase in protected region.
// RQ2 - Load protection register from nonvolatile byte.
// RQ3 - Protection register writable only from debug.
// RQ4 - Boundary bits form last unprotected address.
// RQ5 - Disable bit set means nothing protected.
// RQ6 - Redirect only when redirect-disable bit clear.
// RQ7 - Redirect only under partial protection.
// RQ8 - Redirect interrupt vectors, never reset vector.
// RQ9 - Redirected fetch uses area below boundary.
// RQ10 - Secured: block unsecure and debug memory access.
// RQ11 - Secure code keeps full access.
// RQ12 - Load options register from nonvolatile byte.
// RQ13 - Only security code 1:0 means unsecured.
// RQ14 - Secured: no debug module, pin-gated background.
// RQ15 - Key-enable zero disables the backdoor key.
// RQ16 - Key access turns key writes into compares.
// RQ17 - Software writes key bytes in order, spaced.
// RQ18 - Key match on clear forces security open.
// RQ19 - Key entry only from secure code.
// RQ20 - Blank flash check disengages security.
// RQ21 - Developers program security low bit after erase.
// RQ22 - Wrong or disabled key changes nothing.
// RQ23 - Options register ignores all writes.
module fps_protect (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave.
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic              wb_dbg_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Nonvolatile bytes and stored key from the array, and the background mode pin.
    input  wire logic [7:0]        nv_protection_byte_i,
    input  wire logic [7:0]        nv_options_byte_i,
    input  wire logic [63:0]       backdoor_key_locations_i,
    input  wire logic              background_mode_pin_i,
    // Core and debug memory path.
    input  wire fps_pkg::fps_mreq_s core_req_i,
    output fps_pkg::fps_areq_s     arr_req_o,
    input  wire logic [7:0]        arr_rdata_i,
    output logic [7:0]             core_rdata_o,
    // Program and erase check from the command sequencer.
    input  wire logic              pe_req_i,
    input  wire logic [15:0]       pe_addr_i,
    output logic                   pe_block_o,
    input  wire logic              blank_ok_i,
    // Security state.
    output logic                   secured_o,
    output logic                   debug_module_allow_o,
    output logic                   active_bkgd_allow_o
);

    logic [7:0]       protection_working_reg_r;
    logic [7:0]       options_working_reg_r;
    logic [7:0]       flash_config_reg_r;
    logic [1:0]       sec_field_r;
    logic             load_pend_r;
    logic             pin_s1_r;
    logic             pin_s2_r;
    logic             bkgd_low_r;
    logic             ack_r;
    logic [31:0]      dat_r;
    logic [7:0]       rdata_r;
    fps_pkg::fps_key_e key_st_r;
    fps_pkg::fps_key_e key_st_nxt;
    logic [3:0]       key_idx_r;
    logic             key_bad_r;

    // Protection boundary.
    wire              protect_disable;
    wire [6:0]        protect_boundary_bits;
    wire [15:0]       last_unprot;
    wire              prot_en;
    wire              prot_partial;
    wire              redir_act;

    assign protect_disable       = protection_working_reg_r[fps_pkg::PROT_DIS_BIT];
    assign protect_boundary_bits = protection_working_reg_r[7:1];
    // RQ4 boundary address form
    assign last_unprot = {protect_boundary_bits, {fps_pkg::BLOCK_BITS{1'b1}}};
    // RQ5 disable bit gate
    assign prot_en = !protect_disable;
    // RQ7 partial protection only
    assign prot_partial = prot_en && (last_unprot != fps_pkg::FLASH_TOP)
                          && (last_unprot >= fps_pkg::FLASH_BASE);
    // RQ6 redirect disable bit
    assign redir_act = prot_partial
                       && !options_working_reg_r[fps_pkg::OPT_NORED_BIT];

    // RQ1 block program and erase
    assign pe_block_o = pe_req_i && prot_en && (pe_addr_i > last_unprot);

    // Security state.
    wire backdoor_key_enable;
    wire key_acc;
    wire secured;

    assign backdoor_key_enable   = options_working_reg_r[fps_pkg::OPT_BACKDOOR_KEY_ENABLE_BIT];
    assign key_acc = flash_config_reg_r[fps_pkg::CFG_KEY_ACCESS_BIT_BIT];
    // RQ13 only 1:0 unsecures
    assign secured = (sec_field_r != fps_pkg::SEC_OPEN);

    assign secured_o = secured;
    // RQ14 debug module refused
    assign debug_module_allow_o = !secured;
    // RQ14 background entry via pin
    assign active_bkgd_allow_o = !secured || bkgd_low_r;

    // Access classification.
    wire in_flash;
    wire in_ram;
    wire in_vec;
    wire in_key;
    wire src_untrusted;
    wire blocked;
    wire key_wr;

    assign in_flash = core_req_i.addr >= fps_pkg::FLASH_BASE;
    assign in_ram   = (core_req_i.addr >= fps_pkg::RAM_BASE)
                      && (core_req_i.addr <= fps_pkg::RAM_TOP);
    assign in_vec   = (core_req_i.addr >= fps_pkg::VEC_LO)
                      && (core_req_i.addr <= fps_pkg::VEC_HI);
    assign in_key   = core_req_i.addr[15:3] == fps_pkg::KEY_BASE[15:3];
    // RQ11 secure code trusted
    assign src_untrusted = !core_req_i.src_secure || core_req_i.src_bdc;
    // RQ10 secured access gate
    assign blocked = secured && (in_flash || in_ram) && src_untrusted;
    // RQ16 key writes become compares
    // RQ19 only secure code enters key
    assign key_wr = core_req_i.valid && core_req_i.we && in_key
                    && key_acc && backdoor_key_enable && !src_untrusted;

    // Array request: blocked and key writes never reach the array.
    wire        vec_redir;
    wire [15:0] arr_addr;

    // RQ8 interrupt vectors only
    assign vec_redir = redir_act && in_vec && !core_req_i.we;
    // RQ9 area below boundary
    assign arr_addr = vec_redir
        ? {last_unprot[15:fps_pkg::VEC_AREA_BITS],
           core_req_i.addr[fps_pkg::VEC_AREA_BITS-1:0]}
        : core_req_i.addr;

    assign arr_req_o.valid = core_req_i.valid && !blocked && !key_wr;
    assign arr_req_o.addr  = arr_addr;
    assign arr_req_o.we    = core_req_i.we;
    assign arr_req_o.wdata = core_req_i.wdata;

    // Wishbone decode.
    wire wb_req;
    wire wr_fire;
    wire sel_prot;
    wire sel_opt;
    wire sel_cfg;
    wire sel_stat;
    wire wr_prot;
    wire wr_cfg;
    wire [31:0] rd_mux;

    assign wb_req   = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where the master sees ack.
    assign wr_fire  = wb_req && wb_we_i && wb_sel_i[0] && ack_r;
    assign sel_prot = wb_adr_i == fps_pkg::ADR_PROT;
    assign sel_opt  = wb_adr_i == fps_pkg::ADR_OPT;
    assign sel_cfg  = wb_adr_i == fps_pkg::ADR_CFG;
    assign sel_stat = wb_adr_i == fps_pkg::ADR_STAT;
    // RQ3 debug-only protection write
    assign wr_prot  = wr_fire && sel_prot && wb_dbg_i;
    assign wr_cfg   = wr_fire && sel_cfg;

    wire [7:0] opt_view;
    wire [7:0] stat_view;

    assign opt_view  = {options_working_reg_r[7:2], sec_field_r}
                       & fps_pkg::OPT_MASK;
    assign stat_view = {2'h0, key_bad_r, bkgd_low_r, redir_act,
                        prot_partial, prot_en, secured};

    assign rd_mux = sel_prot ? {24'h0, protection_working_reg_r}
                  : sel_opt  ? {24'h0, opt_view}
                  : sel_cfg  ? {24'h0, flash_config_reg_r}
                  : sel_stat ? {24'h0, stat_view}
                  : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= wb_req && !ack_r;
            dat_r <= rd_mux;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Background pin: synchronised, caught on the first cycle after reset.
    always_ff @(posedge clk_i) begin
        pin_s1_r <= background_mode_pin_i;
        pin_s2_r <= pin_s1_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_pend_r <= 1'b1;
            bkgd_low_r  <= 1'b0;
        end else begin
            load_pend_r <= 1'b0;
            if (load_pend_r) begin
                bkgd_low_r <= !pin_s2_r;
            end
        end
    end

    // Protection register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            protection_working_reg_r <= fps_pkg::PROT_RST;
        end else if (load_pend_r) begin
            // RQ2 copy protection byte
            protection_working_reg_r <= nv_protection_byte_i;
        end else if (wr_prot) begin
            protection_working_reg_r <= wb_dat_i[7:0];
        end
    end

    // Options register: no bus write path at all.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            options_working_reg_r <= fps_pkg::OPT_RST;
        end else if (load_pend_r) begin
            // RQ12 copy options byte
            // RQ23 only reset reloads
            options_working_reg_r <= nv_options_byte_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_config_reg_r <= fps_pkg::CFG_RST;
        end else if (wr_cfg) begin
            flash_config_reg_r <= wb_dat_i[7:0]
                & (8'h01 << fps_pkg::CFG_KEY_ACCESS_BIT_BIT);
        end
    end

    // Backdoor key entry.
    wire [7:0] key_byte;
    wire       key_hit;
    wire       key_clear;
    wire       key_match;
    wire       blank_unlock;

    assign key_byte  = backdoor_key_locations_i[key_idx_r[2:0]*8 +: 8];
    // RQ17 ascending order expected
    assign key_hit   = (core_req_i.addr[2:0] == key_idx_r[2:0])
                       && (core_req_i.wdata == key_byte);
    assign key_clear = wr_cfg && key_acc
                       && !wb_dat_i[fps_pkg::CFG_KEY_ACCESS_BIT_BIT];
    // RQ15 key disabled by bit
    // RQ22 mismatch leaves security
    assign key_match = key_clear && backdoor_key_enable && !key_bad_r
                       && (key_st_r == fps_pkg::KEY_FULL);
    // RQ20 blank check unsecures
    assign blank_unlock = blank_ok_i;

    always_comb begin
        key_st_nxt = key_st_r;
        case (key_st_r)
            fps_pkg::KEY_IDLE: begin
                if (key_acc && backdoor_key_enable) begin
                    key_st_nxt = fps_pkg::KEY_ENTRY;
                end
            end
            fps_pkg::KEY_ENTRY: begin
                if (!key_acc) begin
                    key_st_nxt = fps_pkg::KEY_IDLE;
                end else if (key_wr
                             && key_idx_r == 4'(fps_pkg::KEY_LEN - 1)) begin
                    key_st_nxt = fps_pkg::KEY_FULL;
                end
            end
            fps_pkg::KEY_FULL: begin
                if (!key_acc) begin
                    key_st_nxt = fps_pkg::KEY_IDLE;
                end
            end
            default: begin
                key_st_nxt = fps_pkg::KEY_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_st_r  <= fps_pkg::KEY_IDLE;
            key_idx_r <= 4'h0;
            key_bad_r <= 1'b0;
        end else begin
            key_st_r <= key_st_nxt;
            if (key_st_r == fps_pkg::KEY_IDLE) begin
                key_idx_r <= 4'h0;
                key_bad_r <= 1'b0;
            end else if (key_wr) begin
                key_idx_r <= key_idx_r + 4'h1;
                // A ninth byte or a wrong one spoils the whole entry.
                if (!key_hit || key_st_r == fps_pkg::KEY_FULL) begin
                    key_bad_r <= 1'b1;
                end
            end
        end
    end

    // Security field: once opened it stays open until reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_field_r <= fps_pkg::OPT_RST[1:0];
        end else if (load_pend_r) begin
            sec_field_r <= nv_options_byte_i[1:0];
        end else if (key_match || blank_unlock) begin
            // RQ18 force open code
            sec_field_r <= fps_pkg::SEC_OPEN;
        end
    end

    // Read data: zero for a blocked read, registered one cycle on.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (core_req_i.valid && !core_req_i.we) begin
            // RQ10 blocked reads return zero
            rdata_r <= blocked ? 8'h00 : arr_rdata_i;
        end
    end

    assign core_rdata_o = rdata_r;

    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_pe_top;
        pe_req_i && prot_en && pe_addr_i == fps_pkg::FLASH_TOP |-> pe_block_o;
    endproperty
    a_pe_top: assert property (p_pe_top) else $error("top not protected"); // RQ1

    property p_load_prot;
        load_pend_r |=> protection_working_reg_r == $past(nv_protection_byte_i);
    endproperty
    a_load_prot: assert property (p_load_prot) else $error("prot not loaded"); // RQ2

    property p_app_prot;
        wr_fire && sel_prot && !wb_dbg_i && !load_pend_r
            |=> $stable(protection_working_reg_r);
    endproperty
    a_app_prot: assert property (p_app_prot) else $error("app wrote prot"); // RQ3

    property p_dis_open;
        protect_disable |-> !pe_block_o && !redir_act;
    endproperty
    a_dis_open: assert property (p_dis_open) else $error("disabled yet protects"); // RQ5

    property p_reset_vec;
        core_req_i.valid && core_req_i.addr == 16'hfffe |-> arr_req_o.addr == 16'hfffe;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector moved"); // RQ8

    property p_redir;
        redir_act && core_req_i.valid && !core_req_i.we && core_req_i.addr == 16'hffe0
            |-> arr_req_o.addr == {last_unprot[15:6], 6'h20};
    endproperty
    a_redir: assert property (p_redir) else $error("bad redirect"); // RQ9

    property p_bdc_read;
        secured && core_req_i.valid && !core_req_i.we && core_req_i.src_bdc && in_flash
            |=> core_rdata_o == 8'h00;
    endproperty
    a_bdc_read: assert property (p_bdc_read) else $error("debug read leaked"); // RQ10

    property p_opt_ro;
        !load_pend_r |=> $stable(options_working_reg_r);
    endproperty
    a_opt_ro: assert property (p_opt_ro) else $error("options changed"); // RQ23

    property p_nokey;
        !backdoor_key_enable && !blank_ok_i && !load_pend_r |=> $stable(sec_field_r);
    endproperty
    a_nokey: assert property (p_nokey) else $error("key unlocked"); // RQ15

endmodule // fps_protect

`default_nettype wire

/* tb/fps_core_model.sv */
// Behavioural core and debug controller that issue byte requests, plus array read data.
`timescale 1ns/1ns
`default_nettype none
module fps_core_model (
    input  wire logic               clk_i,
    input  wire fps_pkg::fps_areq_s arr_req_i,
    input  wire logic [7:0]         core_rdata_i,
    output var fps_pkg::fps_mreq_s  core_req_o,
    output logic [7:0]              arr_rdata_o
);
    logic [7:0] idle_pat_r = 8'h00;

    initial core_req_o = '0;

    // A closed array never shows stale data, so a pattern runs between reads.
    always @(posedge clk_i) idle_pat_r <= idle_pat_r + 8'h3b;
    assign arr_rdata_o = arr_req_i.valid ? (arr_req_i.addr[7:0] ^ 8'h5a) : idle_pat_r;

    task automatic mem(input logic [15:0] a, input logic w, input logic [7:0] d,
                       input logic s, input logic b, output logic v,
                       output logic [15:0] aa, output logic [7:0] r);
        core_req_o <= '{1'b1, a, w, d, s, b};
        @(posedge clk_i);
        v = arr_req_i.valid;
        aa = arr_req_i.addr;
        core_req_o.valid <= 1'b0;
        @(posedge clk_i);
        r = core_rdata_i;
    endtask
endmodule // fps_core_model
`default_nettype wire

/* tb/test_flash_protect_and_security.sv */
// Self-checking bench for the flash protection and security block.
`timescale 1ns/1ns
`default_nettype none
module test_flash_protect_and_security;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_dbg = 1'b0;
    logic [3:0]         wb_adr = 4'h0;
    logic [31:0]        wb_dat = 32'h0, wb_dat_o;
    logic               wb_ack_o;
    logic [7:0]         nv_prot = 8'hff, nv_opt = 8'hff, arr_rdata, core_rdata;
    logic [63:0]        key = 64'h0;
    logic               bkgd_pin = 1'b1, pe_req = 1'b0, blank_ok = 1'b0;
    logic [15:0]        pe_addr = 16'h0;
    logic               pe_block, secured, dbg_allow, bkgd_allow;
    fps_pkg::fps_mreq_s mreq;
    fps_pkg::fps_areq_s areq;
    int                 err_total = 0, num_checks = 0, i, k;
    int                 seed = 32'h3b6efccb;
    logic [7:0]         p, o, r;
    logic               v, sec;
    logic [15:0]        aa, a, ea;
    logic [7:0]         ptab [4] = '{8'hfc, 8'hde, 8'hfd, 8'hf8};
    logic [7:0]         otab [4] = '{8'h82, 8'hbe, 8'h83, 8'hc2};
    logic [15:0]        vtab [6] = '{16'hffc0, 16'hffe1, 16'hfffd, 16'hfffe, 16'hffff, 16'hffbf};
    logic [15:0]        gadr [6] = '{16'he100, 16'he100, 16'h0100, 16'h0010, 16'he100, 16'h0100};
    logic [5:0]         gsec = 6'b100000, gbdc = 6'b000010, gwe = 6'b010000;

    always #50 clk_i = ~clk_i;

    fps_protect dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat), .wb_dbg_i(wb_dbg),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nv_protection_byte_i(nv_prot),
        .nv_options_byte_i(nv_opt), .backdoor_key_locations_i(key),
        .background_mode_pin_i(bkgd_pin), .core_req_i(mreq), .arr_req_o(areq),
        .arr_rdata_i(arr_rdata), .core_rdata_o(core_rdata), .pe_req_i(pe_req),
        .pe_addr_i(pe_addr), .pe_block_o(pe_block), .blank_ok_i(blank_ok),
        .secured_o(secured), .debug_module_allow_o(dbg_allow),
        .active_bkgd_allow_o(bkgd_allow)
    );

    fps_core_model core (
        .clk_i(clk_i), .arr_req_i(areq), .core_rdata_i(core_rdata), .core_req_o(mreq),
        .arr_rdata_o(arr_rdata)
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic boot(input logic [7:0] bp, input logic [7:0] bo, input logic pin);
        nv_prot <= bp;
        nv_opt <= bo;
        bkgd_pin <= pin;
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wb(input logic w, input logic [3:0] ad, input logic [7:0] d,
                      input logic g, output logic [7:0] rd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= ad;
        wb_dat <= {24'h0, d};
        wb_dbg <= g;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("Error wb_ack expected 1 seen timeout");
            err_total++;
            conclude();
        end
        rd = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    function automatic logic [15:0] last_of(input logic [7:0] fp);
        return {fp[7:1], 9'h1ff};
    endfunction

    function automatic logic [15:0] redir(input logic [7:0] fp, fo, input logic [15:0] va);
        logic [15:0] l;
        l = last_of(fp);
        if (!fp[0] && !fo[6] && l >= 16'he000 && l != 16'hffff && va >= 16'hffc0 &&
            va <= 16'hfffd) return {l[15:6], va[5:0]};
        return va;
    endfunction

    task automatic gate(input logic s);
        int j;
        logic e;
        for (j = 0; j < 6; j++) begin
            core.mem(gadr[j], gwe[j], 8'h77, gsec[j], gbdc[j], v, aa, r);
            e = !s || gsec[j] || gadr[j] < 16'h0080 || gadr[j] > 16'h027f && gadr[j] < 16'he000;
            chk("gate_valid", v, e);
            if (!gwe[j]) chk("gate_data", r, e ? (gadr[j][7:0] ^ 8'h5a) : 8'h00);
        end
    endtask

    task automatic key_try(input logic [63:0] kv, input logic b, input logic en,
                           input logic exp_sec);
        int j;
        wb(1'b1, 4'h8, 8'h20, 1'b0, r);
        for (j = 0; j < 8; j++) begin
            core.mem(16'hffb0 + 16'(j), 1'b1, kv[8*j +: 8], !b, b, v, aa, r);
            if (en) chk("key_wr_valid", v, 1'b0);
        end
        wb(1'b1, 4'h8, 8'h00, 1'b0, r);
        chk("key_secured", secured, exp_sec);
    endtask

    initial begin
        for (i = 0; i < 10; i++) begin
            p = (i < 4) ? ptab[i] : 8'($random(seed));
            o = (i < 4) ? otab[i] : 8'($random(seed));
            boot(p, o, i[0]);
            wb(1'b0, 4'h0, 8'h00, 1'b0, r);
            chk("prot_reg", r, p);
            wb(1'b0, 4'h4, 8'h00, 1'b0, r);
            chk("opt_reg", r, o & 8'hc3);
            sec = (o[1:0] !== 2'b10);
            chk("secured", secured, sec);
            chk("dbg_module", dbg_allow, !sec);
            if (sec) chk("bkgd_allow", bkgd_allow, !i[0]);
            for (k = 0; k < 6; k++) begin
                a = (k == 0) ? last_of(p) : (k == 1) ? last_of(p) + 16'h1 :
                    (k == 2) ? 16'hffff : 16'he000 | 16'($random(seed));
                pe_req <= 1'b1;
                pe_addr <= a;
                @(posedge clk_i);
                chk("pe_block", pe_block, !p[0] && a > last_of(p));
            end
            pe_req <= 1'b0;
            for (k = 0; k < 6; k++) begin
                ea = redir(p, o, vtab[k]);
                core.mem(vtab[k], 1'b0, 8'h00, 1'b1, 1'b0, v, aa, r);
                chk("vec_addr", aa, ea);
                chk("vec_data", r, ea[7:0] ^ 8'h5a);
            end
        end
        $display("test config_sweep done");
        boot(8'hfc, 8'h82, 1'b1);
        // Open, partial protection, redirect on, pin high, no key error.
        wb(1'b0, 4'hc, 8'h00, 1'b0, r);
        chk("status", r, 8'h0e);
        wb(1'b1, 4'h4, 8'h41, 1'b1, r);
        wb(1'b0, 4'h4, 8'h00, 1'b0, r);
        chk("opt_write", r, 8'h82);
        wb(1'b1, 4'h0, 8'h00, 1'b0, r);
        wb(1'b0, 4'h0, 8'h00, 1'b0, r);
        chk("prot_app_write", r, 8'hfc);
        wb(1'b1, 4'h0, 8'hde, 1'b1, r);
        wb(1'b0, 4'h0, 8'h00, 1'b0, r);
        chk("prot_dbg_write", r, 8'hde);
        wb(1'b0, 4'h1, 8'h00, 1'b0, r);
        chk("unmapped", r, 8'h00);
        $display("test register_access done");
        key = {$random(seed), $random(seed)};
        boot(8'hff, 8'hc3, 1'b1);
        gate(1'b1);
        key_try(~key, 1'b0, 1'b1, 1'b1);
        key_try(key, 1'b1, 1'b1, 1'b1);
        key_try(key, 1'b0, 1'b1, 1'b0);
        gate(1'b0);
        boot(8'hff, 8'hc3, 1'b1);
        chk("sec_after_reset", secured, 1'b1);
        boot(8'hff, 8'h43, 1'b1);
        key_try(key, 1'b0, 1'b0, 1'b1);
        $display("test backdoor_key done");
        blank_ok <= 1'b1;
        @(posedge clk_i);
        blank_ok <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("blank_open", secured, 1'b0);
        boot(8'hff, 8'h42, 1'b1);
        chk("sec_reprog", secured, 1'b0);
        $display("test blank_check done");
        conclude();
    end
endmodule // test_flash_protect_and_security
`default_nettype wire
